/* File: msps_consts.vh */
`ifndef MSPS_CONSTS_VH
`define MSPS_CONSTS_VH

// ****************************************
// mode encodings {mode_select_hi, mode_select_lo}
// ****************************************
`define MSPS_MODE_FULL      2'h0
`define MSPS_MODE_HALF      2'h1
`define MSPS_MODE_QUARTER   2'h2
`define MSPS_MODE_EIGHTH    2'h3

// ****************************************
// position: 32 slots of 11.25 degrees per electrical turn
// ****************************************
`define MSPS_POS_W          5
`define MSPS_INC_FULL       5'h08
`define MSPS_INC_HALF       5'h04
`define MSPS_INC_QUARTER    5'h02
`define MSPS_INC_EIGHTH     5'h01
`define MSPS_POS_INIT_FINE  5'h00
`define MSPS_POS_INIT_FULL  5'h1C
`define MSPS_QUAD_SHIFT     5'h04
`define MSPS_COS_SHIFT      5'h08
`define MSPS_SIN_STEPS      4'h8

// ****************************************
// signed percent levels
// ****************************************
`define MSPS_LVL_W          8
`define MSPS_LVL_100        8'h64
`define MSPS_LVL_98         8'h62
`define MSPS_LVL_92         8'h5C
`define MSPS_LVL_83         8'h53
`define MSPS_LVL_71         8'h47
`define MSPS_LVL_56         8'h38
`define MSPS_LVL_38         8'h26
`define MSPS_LVL_20         8'h14
`define MSPS_LVL_0          8'h00

// ****************************************
// register map (word index on address bits 3:2) and fields
// ****************************************
`define MSPS_REG_CTRL       2'h0
`define MSPS_REG_STATUS     2'h1
`define MSPS_REG_LEVELS     2'h2
`define MSPS_CTRL_RESET     1'h1
`define MSPS_SYNC_W         7

`endif

/* File: msps_sync.v */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// two-stage synchroniser for pin inputs
// ****************************************
module msps_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_i,     // sampling clock
    input  wire             resetn_i,  // async reset, active low
    input  wire [WIDTH-1:0] d_i,       // asynchronous inputs
    output wire [WIDTH-1:0] q_o        // synchronised outputs
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // pins rest low through their pull-downs, so reset to zero
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d_i;
            sync_r <= meta_r;
        end
    end

    assign q_o = sync_r;
endmodule // msps_sync

`default_nettype wire

/* File: msps_sequencer.v */
`timescale 1ns/100ps
`default_nettype none
`include "msps_consts.vh"

module msps_sequencer (
    input  wire        core_clk_i,                   // 25 MHz clock
    input  wire        resetn_i,                     // async reset, low
    input  wire        step_clock_i,                 // step clock pin
    input  wire        rotation_direction_i,         // 0 cw, 1 ccw
    input  wire        mode_select_lo_i,             // mode bit 0
    input  wire        mode_select_hi_i,             // mode bit 1
    input  wire        output_enable_i,              // drive enable pin
    input  wire        seq_reset_n_i,                // sequencer reset
    input  wire        low_power_hold_n_i,           // hold, low
    input  wire [3:0]  avs_address_i,                // byte address
    input  wire        avs_read_i,                   // read request
    input  wire        avs_write_i,                  // write request
    input  wire [31:0] avs_writedata_i,              // write data
    output reg  [31:0] avs_readdata_o,               // read data
    output wire        avs_waitrequest_o,            // stall
    output reg  [7:0]  winding_a_level_o,            // A setpoint, signed %
    output reg  [7:0]  winding_b_level_o,            // B setpoint, signed %
    output reg         winding_a_drive_en_o,         // A bridge active
    output reg         winding_b_drive_en_o,         // B bridge active
    output reg         winding_a_terminal_first_o,   // A first sources
    output reg         winding_a_terminal_second_o,  // A second sources
    output reg         winding_b_terminal_first_o,   // B first sources
    output reg         winding_b_terminal_second_o,  // B second sources
    output wire        home_position_flag_n_o,       // flag, od level
    output reg         home_position_flag_n_oe_o     // flag pulls low
);
    // ****************************************
    // pin synchronisation
    // ****************************************
    wire [`MSPS_SYNC_W-1:0] pins_s;
    wire step_s;
    wire dir_s;
    wire [1:0] mode_s;
    wire en_s;
    wire rst_s;
    wire hold_n_s;

    msps_sync #(
        .WIDTH (`MSPS_SYNC_W)
    ) u_sync (
        .clk_i    (core_clk_i),
        .resetn_i (resetn_i),
        .d_i      ({low_power_hold_n_i, seq_reset_n_i, output_enable_i,
                    mode_select_hi_i, mode_select_lo_i,
                    rotation_direction_i, step_clock_i}),
        .q_o      (pins_s)
    );

    assign step_s   = pins_s[0];
    assign dir_s    = pins_s[1];
    assign mode_s   = pins_s[3:2];
    assign en_s     = pins_s[4];
    assign rst_s    = pins_s[5];
    assign hold_n_s = pins_s[6];

    // ****************************************
    // edge detection and mode decode
    // ****************************************
    reg step_q_r;
    reg rst_q_r;
    wire step_rise = step_s & ~step_q_r;
    wire rst_rise  = rst_s & ~rst_q_r;
    reg [`MSPS_POS_W-1:0] inc;
    reg [`MSPS_POS_W-1:0] init_pos;

    always @* begin
        inc      = `MSPS_INC_EIGHTH;
        init_pos = `MSPS_POS_INIT_FINE;
        case (mode_s)
            `MSPS_MODE_FULL: begin
                inc      = `MSPS_INC_FULL;
                init_pos = `MSPS_POS_INIT_FULL;
            end
            `MSPS_MODE_HALF:    inc = `MSPS_INC_HALF;
            `MSPS_MODE_QUARTER: inc = `MSPS_INC_QUARTER;
            `MSPS_MODE_EIGHTH:  inc = `MSPS_INC_EIGHTH;
            default:            inc = `MSPS_INC_EIGHTH;
        endcase
    end

    // ****************************************
    // position counter
    // ****************************************
    reg [`MSPS_POS_W-1:0] pos_r;
    reg [`MSPS_POS_W-1:0] pos_nxt;
    // a release with the clock already high counts as the edge
    wire advance = hold_n_s & rst_s &
                   (step_rise | (rst_rise & step_s));
    // a release counts from the home of the mode now on the pins, as
    // the mode pins may settle in the same cycle as the release
    wire [`MSPS_POS_W-1:0] pos_base = rst_rise ? init_pos : pos_r;

    always @* begin
        pos_nxt = pos_base;
        if (!hold_n_s || !rst_s) begin
            pos_nxt = init_pos;
        end else if (advance) begin
            // enable is not looked at: stepping goes on undriven
            if (dir_s) begin
                pos_nxt = pos_base - inc;
            end else begin
                pos_nxt = pos_base + inc;
            end
        end
    end

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            step_q_r <= 1'b0;
            rst_q_r  <= 1'b0;
            pos_r    <= `MSPS_POS_INIT_FINE;
        end else begin
            step_q_r <= step_s;
            rst_q_r  <= rst_s;
            pos_r    <= pos_nxt;
        end
    end

    // ****************************************
    // sine lookup, one quadrant of nine entries
    // ****************************************
    function [7:0] msps_quarter;
        input [3:0] idx;
        begin
            case (idx)
                4'h0:    msps_quarter = `MSPS_LVL_0;
                4'h1:    msps_quarter = `MSPS_LVL_20;
                4'h2:    msps_quarter = `MSPS_LVL_38;
                4'h3:    msps_quarter = `MSPS_LVL_56;
                4'h4:    msps_quarter = `MSPS_LVL_71;
                4'h5:    msps_quarter = `MSPS_LVL_83;
                4'h6:    msps_quarter = `MSPS_LVL_92;
                4'h7:    msps_quarter = `MSPS_LVL_98;
                default: msps_quarter = `MSPS_LVL_100;
            endcase
        end
    endfunction

    function [7:0] msps_sine;
        input [4:0] k;
        reg   [7:0] mag;
        begin
            mag = k[3] ? msps_quarter(`MSPS_SIN_STEPS - {1'b0, k[2:0]})
                       : msps_quarter({1'b0, k[2:0]});
            msps_sine = k[4] ? (8'h00 - mag) : mag;
        end
    endfunction

    // ****************************************
    // setpoint generation
    // ****************************************
    reg  [7:0] lvl_a;
    reg  [7:0] lvl_b;
    wire [`MSPS_POS_W-1:0] pos_cos  = pos_r + `MSPS_COS_SHIFT;
    wire [`MSPS_POS_W-1:0] pos_quad = pos_r + `MSPS_QUAD_SHIFT;

    always @* begin
        lvl_a = msps_sine(pos_cos);
        lvl_b = msps_sine(pos_r);
        if (mode_s == `MSPS_MODE_FULL) begin
            // both windings at full: vector length 141.42
            case (pos_quad[4:3])
                2'h0: begin
                    lvl_a = `MSPS_LVL_100;
                    lvl_b = 8'h00 - `MSPS_LVL_100;
                end
                2'h1: begin
                    lvl_a = `MSPS_LVL_100;
                    lvl_b = `MSPS_LVL_100;
                end
                2'h2: begin
                    lvl_a = 8'h00 - `MSPS_LVL_100;
                    lvl_b = `MSPS_LVL_100;
                end
                default: begin
                    lvl_a = 8'h00 - `MSPS_LVL_100;
                    lvl_b = 8'h00 - `MSPS_LVL_100;
                end
            endcase
        end
    end

    // ****************************************
    // register bus
    // ****************************************
    reg  ack_r;
    reg  soft_en_r;
    wire req = avs_read_i | avs_write_i;
    wire [1:0] reg_idx = avs_address_i[3:2];
    assign avs_waitrequest_o = req & ~ack_r;

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_r          <= 1'b0;
            soft_en_r      <= `MSPS_CTRL_RESET;
            avs_readdata_o <= 32'h00000000;
        end else begin
            ack_r <= req & ~ack_r;
            // a write lands on the edge that sees waitrequest low
            if (avs_write_i && ack_r && reg_idx == `MSPS_REG_CTRL) begin
                soft_en_r <= avs_writedata_i[0];
            end
            if (avs_read_i && !ack_r) begin
                case (reg_idx)
                    `MSPS_REG_CTRL:
                        avs_readdata_o <= {31'h00000000, soft_en_r};
                    `MSPS_REG_STATUS:
                        avs_readdata_o <= {18'h00000,
                                           winding_a_drive_en_o,
                                           home_position_flag_n_oe_o,
                                           2'h0, mode_s,
                                           3'h0, pos_r};
                    `MSPS_REG_LEVELS:
                        avs_readdata_o <= {16'h0000, winding_b_level_o,
                                           winding_a_level_o};
                    default:
                        avs_readdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // winding drive and home flag
    // ****************************************
    // drive follows the live position, so re-enable lands where
    // the counter got to rather than where drive stopped
    wire drive = hold_n_s & en_s & soft_en_r;
    wire at_home = (pos_r == init_pos);
    assign home_position_flag_n_o = 1'b0;

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            winding_a_level_o           <= `MSPS_LVL_100;
            winding_b_level_o           <= `MSPS_LVL_0;
            winding_a_drive_en_o        <= 1'b0;
            winding_b_drive_en_o        <= 1'b0;
            winding_a_terminal_first_o  <= 1'b0;
            winding_a_terminal_second_o <= 1'b0;
            winding_b_terminal_first_o  <= 1'b0;
            winding_b_terminal_second_o <= 1'b0;
            home_position_flag_n_oe_o   <= 1'b1;
        end else begin
            winding_a_level_o    <= lvl_a;
            winding_b_level_o    <= lvl_b;
            winding_a_drive_en_o <= drive;
            winding_b_drive_en_o <= drive;
            // sign bit picks the sourcing terminal
            winding_a_terminal_first_o  <= drive & ~lvl_a[7] &
                                           (lvl_a != 8'h00);
            winding_a_terminal_second_o <= drive & lvl_a[7];
            winding_b_terminal_first_o  <= drive & ~lvl_b[7] &
                                           (lvl_b != 8'h00);
            winding_b_terminal_second_o <= drive & lvl_b[7];
            home_position_flag_n_oe_o   <= ~rst_s | at_home;
        end
    end
endmodule // msps_sequencer

`default_nettype wire

/* File: msps_chk_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// pin-level checks of the sequencer
// ****************************************
module msps_chk (
    input wire        core_clk_i,                  // clock
    input wire        resetn_i,                    // reset, low
    input wire        mode_select_lo_i,            // mode bit 0
    input wire        mode_select_hi_i,            // mode bit 1
    input wire        output_enable_i,             // enable pin
    input wire        seq_reset_n_i,               // seq reset
    input wire        low_power_hold_n_i,          // hold pin
    input wire [3:0]  avs_address_i,               // address
    input wire        avs_read_i,                  // read
    input wire        avs_write_i,                 // write
    input wire [31:0] avs_readdata_o,              // read data
    input wire        avs_waitrequest_o,           // stall
    input wire [7:0]  winding_a_level_o,           // a level
    input wire [7:0]  winding_b_level_o,           // b level
    input wire        winding_a_drive_en_o,        // a drive
    input wire        winding_b_drive_en_o,        // b drive
    input wire        winding_a_terminal_first_o,  // a first
    input wire        winding_a_terminal_second_o, // a second
    input wire        home_position_flag_n_o,      // flag data
    input wire        home_position_flag_n_oe_o    // flag pull
);
    wire [7:0] a_mag = winding_a_level_o[7] ? -winding_a_level_o
                                            : winding_a_level_o;
    wire [7:0] b_mag = winding_b_level_o[7] ? -winding_b_level_o
                                            : winding_b_level_o;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // pins pass two sync stages, so allow a few cycles of settling
    a_term_excl: assert property (
        !(winding_a_terminal_first_o && winding_a_terminal_second_o))
        else $error("both a terminals sourcing");
    a_term_pos: assert property (
        winding_a_terminal_first_o |-> !winding_a_level_o[7]
            && winding_a_level_o != 8'h00 && winding_a_drive_en_o)
        else $error("a first terminal with non-positive level");
    a_term_neg: assert property (
        winding_a_terminal_second_o |-> winding_a_level_o[7])
        else $error("a second terminal with non-negative level");
    a_oe_off: assert property (
        (!output_enable_i)[*4] |-> !winding_a_drive_en_o
            && !winding_b_drive_en_o)
        else $error("drive on while enable low");
    a_hold_float: assert property (
        (!low_power_hold_n_i)[*4] |-> !winding_a_drive_en_o
            && !winding_b_drive_en_o)
        else $error("drive on during hold");
    a_init_hold: assert property (
        (!seq_reset_n_i)[*5] |-> home_position_flag_n_oe_o
            && winding_a_level_o == 8'h64)
        else $error("not at initial position in reset");
    a_flag_low: assert property (
        home_position_flag_n_o == 1'b0)
        else $error("flag data not low");
    a_full_mag: assert property (
        ({mode_select_hi_i, mode_select_lo_i} == 2'h0)[*6]
            |-> a_mag == 8'h64 && b_mag == 8'h64)
        else $error("full step level not 100");
    a_bus_wait: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o
            |=> !avs_waitrequest_o)
        else $error("bus answer late");
    a_unmapped_zero: assert property (
        avs_read_i && avs_address_i[3:2] == 2'h3 && avs_waitrequest_o
            |=> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    c_oe_off: cover property ((!output_enable_i)[*4]);
    c_hold: cover property ((!low_power_hold_n_i)[*4]);
    c_full: cover property (({mode_select_hi_i, mode_select_lo_i} == 2'h0)[*6]);
endmodule // msps_chk
bind msps_sequencer msps_chk chk_u (.core_clk_i, .resetn_i,
    .mode_select_lo_i, .mode_select_hi_i, .output_enable_i,
    .seq_reset_n_i, .low_power_hold_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
    .winding_a_level_o, .winding_b_level_o, .winding_a_drive_en_o,
    .winding_b_drive_en_o, .winding_a_terminal_first_o,
    .winding_a_terminal_second_o, .home_position_flag_n_o,
    .home_position_flag_n_oe_o);
`default_nettype wire

/* File: msps_step_ctl.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// step and direction source, 320 ns step period
// ****************************************
module msps_step_ctl (
    input  wire logic core_clk_i,          // clock
    output var  logic step_clock_o,        // step pin
    output var  logic rotation_direction_o // 0 cw, 1 ccw
);
    initial begin
        step_clock_o = 1'b0;
        rotation_direction_o = 1'b0;
    end
    // a new direction settles a cycle ahead of the rise; otherwise
    // rises come every 8 cycles and the step idles low between calls
    task automatic steps(input int n, input logic d);
        if (rotation_direction_o !== d) begin
            rotation_direction_o <= d;
            @(posedge core_clk_i);
        end
        repeat (n) begin
            step_clock_o <= 1'b1;
            repeat (4) @(posedge core_clk_i);
            step_clock_o <= 1'b0;
            repeat (4) @(posedge core_clk_i);
        end
    endtask
    task automatic hold_level(input logic v);
        @(posedge core_clk_i);
        step_clock_o <= v;
    endtask
endmodule // msps_step_ctl
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [7:0] LV [0:8] = '{8'h00, 8'h14, 8'h26, 8'h38,
        8'h47, 8'h53, 8'h5C, 8'h62, 8'h64};
    logic        clk;
    logic        rst_n;
    logic [1:0]  mode;
    logic        oe;
    logic        srst_n;
    logic        hold_n;
    logic [3:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] q;
    logic [4:0]  ep;
    wire  [31:0] rdata;
    wire         waitreq;
    wire  [7:0]  lva;
    wire  [7:0]  lvb;
    wire         dea, deb, ta1, ta2, tb1, tb2, flg, flg_oe, stp, dir;
    int          n_fail, samples_checked;
    int          cyc = 0;
    msps_step_ctl ctl_u (.core_clk_i(clk), .step_clock_o(stp),
        .rotation_direction_o(dir));
    msps_sequencer dut_u (.core_clk_i(clk), .resetn_i(rst_n),
        .step_clock_i(stp), .rotation_direction_i(dir),
        .mode_select_lo_i(mode[0]), .mode_select_hi_i(mode[1]),
        .output_enable_i(oe), .seq_reset_n_i(srst_n),
        .low_power_hold_n_i(hold_n), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .winding_a_level_o(lva), .winding_b_level_o(lvb),
        .winding_a_drive_en_o(dea), .winding_b_drive_en_o(deb),
        .winding_a_terminal_first_o(ta1), .winding_a_terminal_second_o(ta2),
        .winding_b_terminal_first_o(tb1), .winding_b_terminal_second_o(tb2),
        .home_position_flag_n_o(flg), .home_position_flag_n_oe_o(flg_oe));
    initial clk = 1'b0;
    always #20 clk = ~clk;
    function automatic logic [7:0] sn(input logic [4:0] p);
        logic [7:0] m;
        m = LV[p[3] ? 4'h8 - p[2:0] : {1'b0, p[2:0]}];
        return p[4] ? -m : m;
    endfunction
    task automatic final_report();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, exp, input string s);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD %0t %s", $time, s);
            n_fail++;
        end
    endtask
    // full step only ever sits on odd multiples of 45 degrees
    task automatic expect_pos();
        logic [7:0] ea, eb;
        logic       drv;
        ea = sn(ep + 5'h08);
        eb = sn(ep);
        drv = oe && hold_n;
        if (mode == 2'h0) begin
            ea = ea[7] ? 8'h9C : 8'h64;
            eb = eb[7] ? 8'h9C : 8'h64;
        end
        cmp(lva, ea, "level a");
        cmp(lvb, eb, "level b");
        cmp({4'h0, ta1, ta2, tb1, tb2},
            {4'h0, drv && !ea[7] && ea != 8'h00, drv && ea[7],
             drv && !eb[7] && eb != 8'h00, drv && eb[7]},
            "terminals");
        cmp({7'h0, flg_oe}, {7'h0, ep == (mode == 2'h0 ? 5'h1C : 5'h00)},
            "home flag");
    endtask
    task automatic run_steps(input int n, input logic d);
        logic [4:0] inc;
        inc = 5'h08 >> mode;
        repeat (n) begin
            ctl_u.steps(1, d);
            ep = d ? ep - inc : ep + inc;
            expect_pos();
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        {rst_n, mode, oe, srst_n, hold_n} = 6'h0F;
        {addr, rd, wr, wdata, n_fail, samples_checked, ep} = '0;
        repeat (3) @(posedge clk);
        cmp(lva, 8'h64, "reset a");
        cmp(lvb, 8'h00, "reset b");
        rst_n <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            mode <= m[1:0];
            srst_n <= 1'b0;
            repeat (6) @(posedge clk);
            srst_n <= 1'b1;
            repeat (8) @(posedge clk);
            ep = (m == 0) ? 5'h1C : 5'h00;
            expect_pos();
            run_steps(5, 1'b0);
            run_steps(6, 1'b1);
        end
        oe <= 1'b0;
        repeat (6) @(posedge clk);
        cmp({6'h0, dea, deb}, 8'h00, "drive while off");
        run_steps(3, 1'b0);
        oe <= 1'b1;
        repeat (6) @(posedge clk);
        cmp({6'h0, dea, deb}, 8'h03, "drive back");
        expect_pos();
        hold_n <= 1'b0;
        repeat (6) @(posedge clk);
        cmp({6'h0, dea, deb}, 8'h00, "drive in hold");
        ep = 5'h00;
        run_steps(0, 1'b0);
        ctl_u.steps(2, 1'b0);
        expect_pos();
        hold_n <= 1'b1;
        srst_n <= 1'b0;
        ctl_u.hold_level(1'b1);
        repeat (6) @(posedge clk);
        srst_n <= 1'b1;
        repeat (8) @(posedge clk);
        ep = 5'h01;
        expect_pos();
        ctl_u.hold_level(1'b0);
        bus(1'b0, 4'h4, 32'h0);
        cmp(q[7:0], {3'h0, ep}, "status position");
        cmp({6'h0, q[9:8]}, 8'h03, "status mode");
        cmp({6'h0, q[13:12]}, 8'h02, "status flags");
        cmp({7'h0, flg}, 8'h00, "flag data");
        bus(1'b1, 4'h0, 32'h0);
        repeat (4) @(posedge clk);
        cmp({6'h0, dea, deb}, 8'h00, "soft off");
        bus(1'b1, 4'h0, 32'h1);
        bus(1'b0, 4'hC, 32'h0);
        cmp(q[7:0] | q[15:8] | q[23:16] | q[31:24], 8'h00, "unmapped");
        repeat (4) @(posedge clk);
        cmp({6'h0, dea, deb}, 8'h03, "soft on");
        final_report();
    end
endmodule // tb
`default_nettype wire
